// [rtl/swm_slave.sv]
// Overview of operation
// - Every exchange starts with reset then presence before commands count.
// - Device waits 15 to 60 us after reset rising edge.
// - Device presence pulse holds line low 60 to 240 us.
// - Master starts every slot; device only drives presence unprompted.
// - ROM command (skip) then function command precede any data.
// - Device samples line once 15 to 60 us after fall.
// - Device drives read bit within 15 us of slot start.
// - Temperature conversion command then read slots poll completion.
// - Voltage conversion command then read slots poll completion.
// - Recall loads stored page into scratchpad before reading.
// - Page zero read returns eight data bytes then CRC byte.
// - Page one holds integrating current accumulator at byte 04h.
// - Page seven holds charge at 04h-05h, discharge at 06h-07h.
// - Poll read slots return 0 while busy, 1 when done.
// - Temperature conversion completes within 10 ms.
`timescale 1ns/10ps
module swm_slave (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  input  wire logic        DQ_IN,
  output logic             DQ_OUT,
  output logic             DQ_OE_N,
  input  wire logic [15:0] TEMP_VALUE,
  input  wire logic [15:0] VOLT_VALUE,
  input  wire logic [15:0] CURR_VALUE,
  input  wire logic [7:0]  INTEGRATING_CURRENT_ACCUMULATOR,
  input  wire logic [15:0] CHARGE_TOTAL_ACCUMULATOR,
  input  wire logic [15:0] DISCHARGE_TOTAL_ACCUMULATOR,
  output logic             TEMP_BUSY,
  output logic             VOLT_BUSY
);
  localparam int CNT_W = swm_pkg::CNT_W;
  // ==========================================================================
  // Line synchronizer and edges
  // ==========================================================================
  logic dq_s1_r, dq_s2_r, dq_d_r;
  logic fall, rise;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      dq_s1_r <= 1'b1;
      dq_s2_r <= 1'b1;
      dq_d_r  <= 1'b1;
    end else begin
      dq_s1_r <= DQ_IN;
      dq_s2_r <= dq_s1_r;
      dq_d_r  <= dq_s2_r;
    end
  end

  assign fall = dq_d_r & ~dq_s2_r;
  assign rise = ~dq_d_r & dq_s2_r;

  // ==========================================================================
  // Low-time counter: detects reset pulses
  // ==========================================================================
  logic [CNT_W-1:0] low_cnt_r;
  logic             long_low;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      low_cnt_r <= '0;
    end else if (dq_s2_r) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != CNT_W'(swm_pkg::RESET_MIN_CYC)) begin
      low_cnt_r <= low_cnt_r + 1'b1;
    end
  end

  assign long_low = !dq_s2_r
                  && (low_cnt_r == CNT_W'(swm_pkg::RESET_MIN_CYC));

  // ==========================================================================
  // Slot engine
  // ==========================================================================
  typedef enum logic [2:0] {
    SL_WAIT_RST, SL_PRES_WAIT, SL_PRES_LOW, SL_READY, SL_SLOT
  } swm_slot_t;

  swm_slot_t        slot_r;
  logic [CNT_W-1:0] tcnt_r;
  logic             bit_drive_r;
  logic             tx_bit;
  logic             bit_done;
  logic             rx_bit;
  logic             pres_end;
  logic             rst_seen_r;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      slot_r      <= SL_WAIT_RST;
      tcnt_r      <= '0;
      bit_drive_r <= 1'b0;
    end else if (long_low) begin
      slot_r      <= SL_WAIT_RST;
      tcnt_r      <= '0;
      bit_drive_r <= 1'b0;
    end else begin
      unique case (slot_r)
        SL_WAIT_RST: begin
          tcnt_r <= '0;
          if (rise && rst_seen_r) begin
            slot_r <= SL_PRES_WAIT;
          end
        end
        SL_PRES_WAIT: begin
          tcnt_r <= tcnt_r + 1'b1;
          if (tcnt_r == CNT_W'(swm_pkg::PRES_WAIT_CYC - 1)) begin
            slot_r <= SL_PRES_LOW;
            tcnt_r <= '0;
          end
        end
        SL_PRES_LOW: begin
          tcnt_r <= tcnt_r + 1'b1;
          if (tcnt_r == CNT_W'(swm_pkg::PRES_LOW_CYC - 1)) begin
            slot_r <= SL_READY;
            tcnt_r <= '0;
          end
        end
        SL_READY: begin
          tcnt_r <= '0;
          if (fall) begin
            slot_r      <= SL_SLOT;
            bit_drive_r <= ~tx_bit;
          end
        end
        SL_SLOT: begin
          tcnt_r <= tcnt_r + 1'b1;
          if (tcnt_r == CNT_W'(swm_pkg::RD_HOLD_CYC - 1)) begin
            slot_r      <= SL_READY;
            bit_drive_r <= 1'b0;
          end
        end
        default: slot_r <= SL_WAIT_RST;
      endcase
    end
  end

  // A finished reset low moves the engine to the presence wait.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_seen_r <= 1'b0;
    end else if (long_low) begin
      rst_seen_r <= 1'b1;
    end else if (rise) begin
      rst_seen_r <= 1'b0;
    end
  end

  assign pres_end = (slot_r == SL_PRES_LOW)
                  && (tcnt_r == CNT_W'(swm_pkg::PRES_LOW_CYC - 1));
  assign bit_done = (slot_r == SL_SLOT)
                  && (tcnt_r == CNT_W'(swm_pkg::WR_SAMPLE_CYC - 1));
  assign rx_bit   = dq_s2_r;

  // ==========================================================================
  // Transaction sequencer
  // ==========================================================================
  swm_pkg::swm_phase_t phase_r;
  logic [7:0]          sh_r;
  logic [2:0]          bcnt_r;
  logic [7:0]          cmd_r;
  logic [3:0]          byte_idx_r;
  logic [7:0]          crc_r;
  logic                poll_t_r;
  logic [7:0]          sp_r [swm_pkg::SP_BYTES];
  logic [7:0]          cur_byte;
  logic                byte_in;
  logic [7:0]          nxt_byte;
  logic [7:0]          crc_nxt;

  assign byte_in  = bit_done && (bcnt_r == 3'h7);
  assign nxt_byte = {rx_bit, sh_r[7:1]};
  assign cur_byte = (byte_idx_r < 4'(swm_pkg::SP_BYTES)) ?
                    sp_r[byte_idx_r[2:0]] :
                    (byte_idx_r == 4'(swm_pkg::SP_CRC_IDX)) ? crc_r :
                    swm_pkg::FILL_ONES;

  always_comb begin
    tx_bit = 1'b1;
    if (phase_r == swm_pkg::SWM_READ) begin
      tx_bit = cur_byte[bcnt_r];
    end else if (phase_r == swm_pkg::SWM_POLL) begin
      tx_bit = poll_t_r ? ~TEMP_BUSY : ~VOLT_BUSY;
    end
  end

  // Reflected CRC8 over each sent scratchpad data bit, polynomial x8+x5+x4+1.
  always_comb begin
    crc_nxt = {1'b0, crc_r[7:1]};
    if (crc_r[0] ^ tx_bit) begin
      crc_nxt = crc_nxt ^ 8'h8C;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_r    <= swm_pkg::SWM_IDLE;
      sh_r       <= '0;
      bcnt_r     <= '0;
      cmd_r      <= '0;
      byte_idx_r <= '0;
      crc_r      <= '0;
    end else if (pres_end) begin
      phase_r    <= swm_pkg::SWM_ROM;
      bcnt_r     <= '0;
      byte_idx_r <= '0;
      crc_r      <= '0;
    end else if (bit_done) begin
      bcnt_r <= bcnt_r + 1'b1;
      sh_r   <= nxt_byte;
      unique case (phase_r)
        swm_pkg::SWM_ROM: if (byte_in) begin
          phase_r <= (nxt_byte == swm_pkg::CMD_SKIP) ?
                     swm_pkg::SWM_FUNC : swm_pkg::SWM_IDLE;
        end
        swm_pkg::SWM_FUNC: if (byte_in) begin
          cmd_r <= nxt_byte;
          if (nxt_byte == swm_pkg::CMD_CONV_T
              || nxt_byte == swm_pkg::CMD_CONV_V) begin
            phase_r <= swm_pkg::SWM_POLL;
          end else if (nxt_byte == swm_pkg::CMD_RECALL
                       || nxt_byte == swm_pkg::CMD_READ_SP) begin
            phase_r <= swm_pkg::SWM_PAGE;
          end else begin
            phase_r <= swm_pkg::SWM_IDLE;
          end
        end
        swm_pkg::SWM_PAGE: if (byte_in) begin
          phase_r <= (cmd_r == swm_pkg::CMD_READ_SP) ?
                     swm_pkg::SWM_READ : swm_pkg::SWM_IDLE;
        end
        swm_pkg::SWM_READ: begin
          if (byte_idx_r < 4'(swm_pkg::SP_BYTES)) begin
            crc_r <= crc_nxt;
          end
          if (bcnt_r == 3'h7 && byte_idx_r != 4'hF) begin
            byte_idx_r <= byte_idx_r + 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // Recall loads the selected stored page into the scratchpad.
  logic recall_go;
  assign recall_go = byte_in && phase_r == swm_pkg::SWM_PAGE
                   && cmd_r == swm_pkg::CMD_RECALL;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < swm_pkg::SP_BYTES; i++) begin
        sp_r[i] <= swm_pkg::FILL_ONES;
      end
    end else if (recall_go) begin
      for (int i = 0; i < swm_pkg::SP_BYTES; i++) begin
        sp_r[i] <= swm_pkg::FILL_ONES;
      end
      unique case (nxt_byte[2:0])
        swm_pkg::PG_MEAS: begin
          sp_r[1] <= TEMP_VALUE[7:0];
          sp_r[2] <= TEMP_VALUE[15:8];
          sp_r[3] <= VOLT_VALUE[7:0];
          sp_r[4] <= VOLT_VALUE[15:8];
          sp_r[5] <= CURR_VALUE[7:0];
          sp_r[6] <= CURR_VALUE[15:8];
        end
        swm_pkg::PG_ICA: begin
          sp_r[swm_pkg::ICA_OFS] <= INTEGRATING_CURRENT_ACCUMULATOR;
        end
        swm_pkg::PG_ACCUM: begin
          sp_r[swm_pkg::CHG_OFS]     <= CHARGE_TOTAL_ACCUMULATOR[7:0];
          sp_r[swm_pkg::CHG_OFS + 1] <= CHARGE_TOTAL_ACCUMULATOR[15:8];
          sp_r[swm_pkg::DIS_OFS]     <= DISCHARGE_TOTAL_ACCUMULATOR[7:0];
          sp_r[swm_pkg::DIS_OFS + 1] <= DISCHARGE_TOTAL_ACCUMULATOR[15:8];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Conversion timers
  // ==========================================================================
  logic [23:0] conv_cnt_r;
  logic        conv_start;

  assign conv_start = byte_in && phase_r == swm_pkg::SWM_FUNC
                    && (nxt_byte == swm_pkg::CMD_CONV_T
                        || nxt_byte == swm_pkg::CMD_CONV_V);

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      conv_cnt_r <= '0;
      TEMP_BUSY  <= 1'b0;
      VOLT_BUSY  <= 1'b0;
      poll_t_r   <= 1'b0;
    end else if (conv_start) begin
      poll_t_r   <= (nxt_byte == swm_pkg::CMD_CONV_T);
      TEMP_BUSY  <= (nxt_byte == swm_pkg::CMD_CONV_T);
      VOLT_BUSY  <= (nxt_byte == swm_pkg::CMD_CONV_V);
      conv_cnt_r <= (nxt_byte == swm_pkg::CMD_CONV_T) ?
                    24'(swm_pkg::TCONV_CYC - 1) :
                    24'(swm_pkg::VCONV_CYC - 1);
    end else if (conv_cnt_r != '0) begin
      conv_cnt_r <= conv_cnt_r - 1'b1;
    end else begin
      TEMP_BUSY <= 1'b0;
      VOLT_BUSY <= 1'b0;
    end
  end

  // ==========================================================================
  // Open-drain pin drive
  // ==========================================================================
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      DQ_OUT  <= 1'b0;
      DQ_OE_N <= 1'b1;
    end else begin
      DQ_OUT  <= 1'b0;
      DQ_OE_N <= ~((slot_r == SL_PRES_LOW)
                 || (slot_r == SL_SLOT && bit_drive_r));
    end
  end

endmodule

// [rtl/swm_pkg.sv]
package swm_pkg;

  // ==========================================================================
  // Line timing
  // ==========================================================================
  localparam int CLK_MHZ          = 100;
  localparam int RESET_MIN_US     = 480;
  localparam int PRES_WAIT_US     = 30;
  localparam int PRES_LOW_US      = 120;
  localparam int WR_SAMPLE_US     = 30;
  localparam int RD_HOLD_US       = 45;
  localparam int RESET_MIN_CYC    = RESET_MIN_US * CLK_MHZ;
  localparam int PRES_WAIT_CYC    = PRES_WAIT_US * CLK_MHZ;
  localparam int PRES_LOW_CYC     = PRES_LOW_US * CLK_MHZ;
  localparam int WR_SAMPLE_CYC    = WR_SAMPLE_US * CLK_MHZ;
  localparam int RD_HOLD_CYC      = RD_HOLD_US * CLK_MHZ;
  localparam int TCONV_MS         = 10;
  localparam int VCONV_MS         = 4;
  localparam int TCONV_CYC        = TCONV_MS * 1000 * CLK_MHZ;
  localparam int VCONV_CYC        = VCONV_MS * 1000 * CLK_MHZ;
  localparam int CNT_W            = 20;

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [7:0] CMD_SKIP    = 8'hCC;
  localparam logic [7:0] CMD_CONV_T  = 8'h44;
  localparam logic [7:0] CMD_CONV_V  = 8'hB4;
  localparam logic [7:0] CMD_RECALL  = 8'hB8;
  localparam logic [7:0] CMD_READ_SP = 8'hBE;
  localparam logic [7:0] FILL_ONES   = 8'hFF;

  // ==========================================================================
  // Scratchpad layout
  // ==========================================================================
  localparam int SP_BYTES     = 8;
  localparam int SP_CRC_IDX   = 8;
  localparam int ICA_OFS      = 4;
  localparam int CHG_OFS      = 4;
  localparam int DIS_OFS      = 6;
  localparam logic [2:0] PG_MEAS  = 3'h0;
  localparam logic [2:0] PG_ICA   = 3'h1;
  localparam logic [2:0] PG_ACCUM = 3'h7;

  typedef enum logic [2:0] {
    SWM_ROM, SWM_FUNC, SWM_PAGE, SWM_POLL, SWM_READ, SWM_IDLE
  } swm_phase_t;

endpackage

// [testbench/swm_slave_sva.sv]
`timescale 1ns/10ps
module swm_slave_chk (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic DQ_IN,
  input wire logic DQ_OUT,
  input wire logic DQ_OE_N,
  input wire logic TEMP_BUSY,
  input wire logic VOLT_BUSY
);
  // ====================================================================
  // Line interval counters
  // ====================================================================
  logic [19:0] hi_r;
  logic [19:0] lo_r;
  logic [19:0] last_lo_r;
  logic [19:0] fall_r;
  logic [19:0] dev_r;
  logic [19:0] tb_r;
  logic [19:0] vb_r;
  logic        pres_r;
  logic        seen_r;
  logic        dq_d_r;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  function automatic logic [19:0] inc(input logic [19:0] v);
    return (&v) ? v : v + 20'h1;
  endfunction

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      hi_r      <= 20'h0;
      lo_r      <= 20'h0;
      last_lo_r <= 20'h0;
      fall_r    <= 20'h0;
      dev_r     <= 20'h0;
      tb_r      <= 20'h0;
      vb_r      <= 20'h0;
      pres_r    <= 1'b0;
      seen_r    <= 1'b0;
      dq_d_r    <= 1'b1;
    end else begin
      dq_d_r <= DQ_IN;
      hi_r   <= DQ_IN ? inc(hi_r) : 20'h0;
      lo_r   <= DQ_IN ? 20'h0 : inc(lo_r);
      fall_r <= (dq_d_r && !DQ_IN) ? 20'h0 : inc(fall_r);
      dev_r  <= DQ_OE_N ? 20'h0 : inc(dev_r);
      tb_r   <= TEMP_BUSY ? inc(tb_r) : 20'h0;
      vb_r   <= VOLT_BUSY ? inc(vb_r) : 20'h0;
      if (DQ_IN && !dq_d_r) begin
        last_lo_r <= lo_r;
      end
      if (DQ_IN && lo_r >= 20'hBB80) begin
        seen_r <= 1'b1;
      end
      if (!DQ_OE_N && dev_r == 20'h0) begin
        pres_r <= hi_r > 20'h8;
      end
    end
  end

  // ====================================================================
  // Assertions
  // ====================================================================
  AST_PULL_ONLY: assert property (!DQ_OE_N |-> !DQ_OUT)
    else $error("Line driven high.");
  AST_AFTER_BUS_RESET: assert property (!DQ_OE_N |-> seen_r)
    else $error("Pull before any bus reset.");
  AST_PRES_WAIT: assert property ($fell(DQ_OE_N) && hi_r > 20'h8 |->
    hi_r >= 20'h5DC && hi_r <= 20'h1773 && last_lo_r >= 20'hBB80)
    else $error("Presence start out of window.");
  AST_PRES_LEN: assert property ($rose(DQ_OE_N) && pres_r |->
    dev_r >= 20'h1770 && dev_r <= 20'h5DC0)
    else $error("Presence length out of range.");
  AST_READ_VALID: assert property ($fell(DQ_OE_N) && hi_r <= 20'h8 |->
    fall_r <= 20'h578)
    else $error("Read bit driven late.");
  AST_READ_HOLD: assert property ($rose(DQ_OE_N) && !pres_r |->
    fall_r >= 20'h5DC && fall_r <= 20'h1770)
    else $error("Read bit released out of window.");
  AST_SYNC_DELAY: assert property ($fell(DQ_IN) && DQ_OE_N |=> DQ_OE_N)
    else $error("Reaction without synchronizer delay.");
  AST_TCONV_BOUND: assert property (TEMP_BUSY |-> tb_r < 20'hF4240)
    else $error("Temperature conversion too long.");
  AST_VCONV_BOUND: assert property (VOLT_BUSY |-> vb_r < 20'h61A80)
    else $error("Voltage conversion too long.");
  AST_TBUSY_START: assert property ($rose(TEMP_BUSY) |->
    fall_r >= 20'h5DC && fall_r <= 20'h1770)
    else $error("Conversion started outside a slot.");

  COV_PRESENCE: cover property ($rose(DQ_OE_N) && pres_r);
  COV_READ_ZERO: cover property ($rose(DQ_OE_N) && !pres_r);
  COV_TCONV: cover property ($rose(TEMP_BUSY));
endmodule

bind swm_slave swm_slave_chk u_chk (
  .CLK_SYS   (CLK_SYS),
  .RESET_N   (RESET_N),
  .DQ_IN     (DQ_IN),
  .DQ_OUT    (DQ_OUT),
  .DQ_OE_N   (DQ_OE_N),
  .TEMP_BUSY (TEMP_BUSY),
  .VOLT_BUSY (VOLT_BUSY)
);

// [testbench/swm_host_model.sv]
`timescale 1ns/10ps
module swm_host_model (
  input  wire logic clk,
  input  wire logic line,
  output logic      pull
);
  initial pull = 1'b0;

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic bus_reset(output logic [19:0] plen);
    plen = 20'h0;
    @(negedge clk);
    pull = 1'b1;
    idle(48100);
    pull = 1'b0;
    for (int i = 0; i < 30000; i++) begin
      @(negedge clk);
      if (!line) begin
        plen = plen + 20'h1;
      end else if (plen != 20'h0) begin
        break;
      end
    end
    idle(100);
  endtask

  task automatic wr_bit(input logic b);
    @(negedge clk);
    pull = 1'b1;
    idle(b ? 200 : 6100);
    pull = 1'b0;
    idle(b ? 6000 : 100);
  endtask

  task automatic wr_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      wr_bit(v[i]);
    end
  endtask

  task automatic rd_bit(output logic b);
    @(negedge clk);
    pull = 1'b1;
    idle(200);
    pull = 1'b0;
    idle(1300);
    b = line;
    idle(4700);
  endtask
endmodule

// [testbench/swm_slave_tb_top.sv]
`timescale 1ns/10ps
module swm_slave_tb_top;
  logic        clk_sys;
  logic        reset_n;
  logic        host_pull;
  logic        dq_out;
  logic        dq_oe_n;
  logic        temp_busy;
  logic        volt_busy;
  logic [15:0] meas;
  wire         dq = !(host_pull || (!dq_oe_n && !dq_out));
  int          failures;
  int          checked;

  swm_slave DUT (
    .CLK_SYS                         (clk_sys),
    .RESET_N                         (reset_n),
    .DQ_IN                           (dq),
    .DQ_OUT                          (dq_out),
    .DQ_OE_N                         (dq_oe_n),
    .TEMP_VALUE                      (meas),
    .VOLT_VALUE                      (~meas),
    .CURR_VALUE                      (meas ^ 16'h0F0F),
    .INTEGRATING_CURRENT_ACCUMULATOR (meas[7:0]),
    .CHARGE_TOTAL_ACCUMULATOR        (meas + 16'h0011),
    .DISCHARGE_TOTAL_ACCUMULATOR     (meas - 16'h0011),
    .TEMP_BUSY                       (temp_busy),
    .VOLT_BUSY                       (volt_busy)
  );

  swm_host_model HOST (
    .clk  (clk_sys),
    .line (dq),
    .pull (host_pull)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ====================================================================
  // Checking and reporting
  // ====================================================================
  task automatic chk(input string what, input logic [19:0] exp,
                     input logic [19:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ====================================================================
  // Scenarios
  // ====================================================================
  task automatic test_no_reset;
    logic b;
    HOST.rd_bit(b);
    chk("read before bus reset", 20'h1, {19'h0, b});
    $display("test_no_reset done");
  endtask

  task automatic test_presence;
    logic [19:0] plen;
    logic        ok;
    HOST.bus_reset(plen);
    ok = plen >= 20'h1770 && plen <= 20'h5DC0;
    chk("presence seen", 20'h1, {19'h0, plen != 20'h0});
    chk("presence length", 20'h1, {19'h0, ok});
    $display("test_presence done");
  endtask

  task automatic test_conv_temp;
    logic b;
    HOST.wr_byte(swm_pkg::CMD_SKIP);
    HOST.wr_byte(swm_pkg::CMD_CONV_T);
    chk("temp busy", 20'h1, {19'h0, temp_busy});
    chk("volt busy", 20'h0, {19'h0, volt_busy});
    for (int i = 0; i < 2; i++) begin
      HOST.rd_bit(b);
      chk("poll while busy", 20'h0, {19'h0, b});
    end
    $display("test_conv_temp done");
  endtask

  initial begin
    failures = 0;
    checked = 0;
    reset_n = 1'b0;
    meas = 16'h5A3C;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    test_no_reset();
    test_presence();
    test_conv_temp();
    summarize();
  end

  // The whole sequence needs about 1.8 ms; this cuts a hang short.
  initial begin
    #3000000;
    failures++;
    summarize();
  end
endmodule
